// File: i2c_status_pkg.sv
// Constants, state layout and register map of the two-wire status and mode block.
`default_nettype none
package i2c_status_pkg;
  // Bus clock and the half bit period of the generated line clock.
  localparam int CLK_MHZ = 100;
  localparam int HALF_NS = 5000;
  localparam logic [9:0] HALF_CYC = 10'((HALF_NS * CLK_MHZ + 999) / 1000);
  // Register byte offsets on the register bus.
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_DATA = 4'h4;
  localparam logic [3:0] OFF_CTRL = 4'h8;
  localparam logic [3:0] OFF_ADDR = 4'hc;
  // Field positions of the status and control registers.
  localparam int ST_PEND = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_TRX = 6;
  localparam int ST_MST = 7;
  localparam int CT_EN = 0;
  localparam int CT_FDF = 1;
  localparam int CT_TEN = 2;
  localparam int CT_ACKCLK = 3;
  localparam int CT_ACKBIT = 4;
  // Bit counter positions within one byte, bus responses and the general call address.
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] GCALL_ADDR = 8'h00;

  typedef enum logic [2:0] {M_IDLE, M_START, M_LOW, M_HIGH, M_STOP1, M_STOP2} mstate_t;

  typedef struct packed {
    logic scl_s1, scl_s2, sda_s1, sda_s2, scl_d, sda_d;
    logic last_received_bit, gcall, amatch, arb, pending, busy, transfer_direction, master_select;
    logic en, fdf, ten, ackclk, ackbit;
    logic [7:0] own;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic framed, addr_phase;
    mstate_t mstate;
    logic [9:0] cnt;
    logic scl_oe_n, sda_oe_n, irq;
    logic awready, wready, aw_got, w_got, wstrb0;
    logic [3:0] awaddr;
    logic [7:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic arready, rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } state_t;

  // Value of the whole state after reset; lines idle high, request bit high.
  localparam state_t STATE_RESET = '{scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1,
    sda_s2: 1'b1, scl_d: 1'b1, sda_d: 1'b1, last_received_bit: 1'b0, gcall: 1'b0, amatch: 1'b0,
    arb: 1'b0, pending: 1'b1, busy: 1'b0, transfer_direction: 1'b0, master_select: 1'b0, en: 1'b0, fdf: 1'b0,
    ten: 1'b0, ackclk: 1'b0, ackbit: 1'b0, own: 8'h00, shift: 8'h00, bitcnt: 4'h0,
    framed: 1'b0, addr_phase: 1'b0, mstate: M_IDLE, cnt: 10'h000, scl_oe_n: 1'b1,
    sda_oe_n: 1'b1, irq: 1'b0, awready: 1'b1, wready: 1'b1, aw_got: 1'b0,
    w_got: 1'b0, wstrb0: 1'b0, awaddr: 4'h0, wdata: 8'h00, bvalid: 1'b0,
    bresp: 2'h0, arready: 1'b1, rvalid: 1'b0, rdata: 8'h00, rresp: 2'h0};
endpackage
`default_nettype wire

// File: i2c_status_mode.sv
// Status and mode flags of a multi-master two-wire interface behind an AXI4-Lite slave.
//
// Notes on behaviour
// - With acknowledge clock on, ack sampled into last bit flag: 0 ack, 1 none.
// - Without acknowledge clock, last bit flag takes the final received data bit.
// - A data register write clears last bit flag and address match flag.
// - As slave, an all-zero address byte sets the general call flag.
// - A START or STOP on the bus clears the general call flag.
// - Seven-bit mode: match on upper seven address bits, or general call.
// - Ten-bit mode: match needs all eight bits including read/write compare bit.
// - Lost arbitration sets its flag, clears direction, master drops after byte.
// - Losing during address byte leaves us receiving to catch our own address.
// - Request bit falls at end of each master or addressed slave byte; interrupt pulses on that fall.
// - While request bit is low the clock line is held low by a master in its low phase or by an addressed slave.
// - Request bit sets on data write, while disabled, and at reset.
// - Request bit clears after sent or received bytes and addressed slave bytes.
// - Busy flag low means START allowed; high blocks START generation.
// - Software writes busy only in master transmit; else START sets, STOP clears.
// - Busy flag is held low while the interface is disabled.
// - Direction low receives; high drives bits onto the data line.
// - Addressed slave takes direction from the address read/write bit unless the fdf bit is set.
// - Direction clears on lost arbitration, STOP, blocked START, slave START, slave NACK.
// - Master generates START, STOP and clocks; slave follows the bus.
// - Master bit clears after a lost byte, on STOP, on blocked START, at reset.
// - A START by another master blocks our START, count reset and clocks.
// - Low status nibble is read only; high nibble is read and write.
`default_nettype none
module i2c_status_mode
  import i2c_status_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [3:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE_N,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  output logic IRQ
);
  state_t s;
  state_t n;
  logic scl_rise, scl_fall, start_det, stop_det, tick;
  logic gc_hit, m7, m10, wr_go, wr_data, wr_status, addressed, done, ack_lo;

  // Line events come only from the second synchroniser stage and its delayed copy.
  assign scl_rise = s.scl_s2 & ~s.scl_d;
  assign scl_fall = ~s.scl_s2 & s.scl_d;
  assign start_det = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
  assign stop_det = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;
  assign tick = (s.cnt == HALF_CYC - 10'h001);

  // Address compare on the byte now in the shift register.
  assign gc_hit = (s.shift == GCALL_ADDR);
  assign m7 = (s.shift[7:1] == s.own[7:1]);
  assign m10 = (s.shift == s.own);
  assign addressed = s.fdf | s.amatch | s.gcall;

  // Register writes fire once both address and data have been taken.
  assign wr_go = s.aw_got & s.w_got & ~s.bvalid;
  assign wr_data = wr_go & (s.awaddr == OFF_DATA) & s.wstrb0 & s.en;
  assign wr_status = wr_go & (s.awaddr == OFF_STATUS) & s.wstrb0;

  // Next-state logic; CPU writes come first so that line events override them.
  always_comb begin
    n = s;
    done = 1'b0;
    ack_lo = 1'b0;
    n.scl_s1 = SCL_IN;
    n.scl_s2 = s.scl_s1;
    n.sda_s1 = SDA_IN;
    n.sda_s2 = s.sda_s1;
    n.scl_d = s.scl_s2;
    n.sda_d = s.sda_s2;
    n.cnt = (s.mstate == M_IDLE) ? 10'h000 : s.cnt + 10'h001;
    if (AWVALID && s.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = AWADDR;
    end
    if (WVALID && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = WDATA[7:0];
      n.wstrb0 = WSTRB[0];
    end
    if (wr_go) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (s.awaddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (s.bvalid && BREADY) begin
      n.bvalid = 1'b0;
    end
    // A data write reloads the byte and releases the held clock.
    if (wr_data) begin
      n.shift = s.wdata;
      n.last_received_bit = 1'b0;
      n.amatch = 1'b0;
      n.pending = 1'b1;
      if (s.framed && s.bitcnt == 4'h0 && !s.scl_s2) begin
        n.sda_oe_n = ~(s.transfer_direction & ~s.wdata[7]);
      end
    end
    // Only the upper nibble of the status register takes writes.
    if (wr_status) begin
      n.pending = s.wdata[ST_PEND];
      if (s.wdata[ST_MST] && s.wdata[ST_TRX]) begin
        if (s.wdata[ST_BUSY] && s.mstate == M_IDLE) begin
          if (s.busy) begin
            n.master_select = 1'b0;
            n.transfer_direction = 1'b0;
          end else begin
            n.master_select = 1'b1;
            n.transfer_direction = 1'b1;
            n.busy = 1'b1;
            n.arb = 1'b0;
            n.sda_oe_n = 1'b0;
            n.mstate = M_START;
            n.cnt = 10'h000;
          end
        end else if (!s.wdata[ST_BUSY] && s.master_select && s.mstate == M_LOW) begin
          n.busy = 1'b0;
          n.sda_oe_n = 1'b0;
          n.mstate = M_STOP1;
          n.cnt = 10'h000;
        end
      end else begin
        n.master_select = s.wdata[ST_MST];
        n.transfer_direction = s.wdata[ST_TRX];
      end
    end
    if (wr_go && s.awaddr == OFF_CTRL && s.wstrb0) begin
      n.en = s.wdata[CT_EN];
      n.fdf = s.wdata[CT_FDF];
      n.ten = s.wdata[CT_TEN];
      n.ackclk = s.wdata[CT_ACKCLK];
      n.ackbit = s.wdata[CT_ACKBIT];
    end
    if (wr_go && s.awaddr == OFF_ADDR && s.wstrb0) begin
      n.own = s.wdata;
    end
    n.awready = ~n.aw_got & ~n.bvalid;
    n.wready = ~n.w_got & ~n.bvalid;
    // Read channel: one read in flight, unmapped offsets answer with an error.
    if (ARVALID && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = (ARADDR[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      case (ARADDR)
        OFF_STATUS: n.rdata = {s.master_select, s.transfer_direction, s.busy, s.pending, s.arb, s.amatch, s.gcall, s.last_received_bit};
        OFF_DATA: n.rdata = s.shift;
        OFF_CTRL: n.rdata = {3'h0, s.ackbit, s.ackclk, s.ten, s.fdf, s.en};
        OFF_ADDR: n.rdata = s.own;
        default: n.rdata = 8'h00;
      endcase
    end else if (s.rvalid && RREADY) begin
      n.rvalid = 1'b0;
    end
    n.arready = ~n.rvalid;
    // Sample the data line on each rising clock edge.
    if (scl_rise) begin
      if (s.bitcnt < ACK_SLOT) begin
        n.shift = {s.shift[6:0], s.sda_s2};
        if (s.master_select && s.transfer_direction && s.sda_oe_n && !s.sda_s2) begin
          n.arb = 1'b1;
          n.transfer_direction = 1'b0;
        end
      end else begin
        if (s.ackclk) begin
          n.last_received_bit = s.sda_s2;
        end
        if (!s.master_select && s.sda_s2) begin
          n.transfer_direction = 1'b0;
        end
      end
    end
    // Count bits on falling edges; the first fall after START only places bit 0.
    if (scl_fall) begin
      if (!s.framed) begin
        n.framed = 1'b1;
      end else if (s.bitcnt == LAST_BIT) begin
        if (s.addr_phase && (!s.master_select || s.arb)) begin
          if (gc_hit) begin
            n.gcall = 1'b1;
          end
          if (s.ten ? m10 : (m7 | gc_hit)) begin
            n.amatch = 1'b1;
            if (!s.fdf) begin
              n.transfer_direction = s.shift[0];
            end
          end
        end
        if (s.ackclk) begin
          n.bitcnt = ACK_SLOT;
        end else begin
          n.bitcnt = 4'h0;
          done = 1'b1;
          n.last_received_bit = s.shift[0];
        end
      end else if (s.bitcnt == ACK_SLOT) begin
        n.bitcnt = 4'h0;
        done = 1'b1;
      end else begin
        n.bitcnt = s.bitcnt + 4'h1;
      end
      // Place the next bit, or the acknowledge, while the clock is low.
      if (s.addr_phase && !s.master_select) begin
        ack_lo = n.amatch | n.gcall;
      end else begin
        ack_lo = ~n.transfer_direction & ~s.ackbit & (s.master_select | n.amatch | n.gcall | s.fdf);
      end
      if (n.bitcnt == ACK_SLOT) begin
        n.sda_oe_n = ~ack_lo;
      end else begin
        n.sda_oe_n = ~(n.transfer_direction & ~n.shift[7] & (s.master_select | n.amatch | n.gcall | s.fdf));
      end
    end
    if (done) begin
      n.addr_phase = 1'b0;
      if (s.master_select || n.amatch || n.gcall || s.fdf) begin
        n.pending = 1'b0;
      end
      if (s.arb) begin
        n.master_select = 1'b0;
      end
    end
    if (start_det) begin
      n.bitcnt = 4'h0;
      n.framed = 1'b0;
      n.addr_phase = 1'b1;
      n.gcall = 1'b0;
      if (!(s.master_select && s.transfer_direction)) begin
        n.busy = 1'b1;
      end
      if (!s.master_select) begin
        n.transfer_direction = 1'b0;
      end
    end
    if (stop_det) begin
      n.gcall = 1'b0;
      n.transfer_direction = 1'b0;
      n.master_select = 1'b0;
      n.framed = 1'b0;
      n.addr_phase = 1'b0;
      if (!(s.master_select && s.transfer_direction)) begin
        n.busy = 1'b0;
      end
    end
    // Master clock engine; a clock held low by a slave stretches the high phase.
    case (s.mstate)
      M_IDLE: begin
        n.cnt = 10'h000;
      end
      M_START: begin
        if (tick) begin
          n.scl_oe_n = 1'b0;
          n.mstate = M_LOW;
          n.cnt = 10'h000;
        end
      end
      M_LOW: begin
        if (!n.master_select) begin
          n.scl_oe_n = 1'b1;
          n.mstate = M_IDLE;
        end else if (!s.pending) begin
          n.cnt = 10'h000;
        end else if (tick) begin
          n.scl_oe_n = 1'b1;
          n.mstate = M_HIGH;
          n.cnt = 10'h000;
        end
      end
      M_HIGH: begin
        if (!n.master_select) begin
          n.mstate = M_IDLE;
        end else if (!s.scl_s2) begin
          n.cnt = 10'h000;
        end else if (tick) begin
          n.scl_oe_n = 1'b0;
          n.mstate = M_LOW;
          n.cnt = 10'h000;
        end
      end
      M_STOP1: begin
        if (tick) begin
          n.scl_oe_n = 1'b1;
          n.mstate = M_STOP2;
          n.cnt = 10'h000;
        end
      end
      M_STOP2: begin
        if (tick) begin
          n.sda_oe_n = 1'b1;
          n.mstate = M_IDLE;
        end
      end
      default: begin
        n.mstate = M_IDLE;
      end
    endcase
    // An addressed slave stretches the clock until software services the byte.
    if (n.mstate == M_IDLE) begin
      n.scl_oe_n = ~(~n.pending & ~n.master_select & n.framed & (n.amatch | n.gcall | s.fdf));
    end
    // Disabled interface lets go of both lines and parks the flags.
    if (!n.en) begin
      n.pending = 1'b1;
      n.busy = 1'b0;
      n.arb = 1'b0;
      n.scl_oe_n = 1'b1;
      n.sda_oe_n = 1'b1;
      n.mstate = M_IDLE;
    end
    n.irq = s.pending & ~n.pending;
  end

  // The whole state is one register.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s <= STATE_RESET;
    end else begin
      s <= n;
    end
  end

  // Open-drain lines only ever pull low; the level comes from the enables.
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE_N = s.scl_oe_n;
  assign SDA_OE_N = s.sda_oe_n;
  assign IRQ = s.irq;
  assign AWREADY = s.awready;
  assign WREADY = s.wready;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign ARREADY = s.arready;
  assign RVALID = s.rvalid;
  assign RDATA = {24'h000000, s.rdata};
  assign RRESP = s.rresp;

  // Checks of the flag behaviour against line events and register writes.
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  sequence s_blocked_start;
    wr_status && s.wdata[ST_MST] && s.wdata[ST_TRX] && s.wdata[ST_BUSY] && s.busy &&
      s.mstate == M_IDLE;
  endsequence
  sequence s_ack_edge;
    scl_rise && s.bitcnt == ACK_SLOT && s.ackclk && !wr_data;
  endsequence
  property p_ack_lrb;
    s_ack_edge |=> (s.last_received_bit == $past(s.sda_s2));
  endproperty
  property p_noack_lrb;
    (scl_fall && s.framed && s.bitcnt == LAST_BIT && !s.ackclk && !wr_data) |=>
      (s.last_received_bit == $past(s.shift[0]));
  endproperty
  property p_data_write;
    (wr_data && !scl_rise && !scl_fall) |=> (!s.last_received_bit && !s.amatch && (s.pending || !s.en));
  endproperty
  property p_gcall_clear;
    (start_det || stop_det) |=> !s.gcall;
  endproperty
  property p_irq;
    $fell(s.pending) |-> IRQ;
  endproperty
  property p_hold_scl;
    (s.mstate == M_LOW && !s.pending) |-> !SCL_OE_N;
  endproperty
  property p_disabled;
    !s.en |-> (s.pending && !s.busy && s.mstate == M_IDLE);
  endproperty
  property p_stop;
    stop_det |=> (!s.transfer_direction && !s.master_select);
  endproperty
  property p_arb;
    (scl_rise && s.bitcnt < ACK_SLOT && s.master_select && s.transfer_direction && s.sda_oe_n && !s.sda_s2) |=>
      (s.arb && !s.transfer_direction);
  endproperty
  property p_blocked;
    s_blocked_start |=> (!s.master_select && s.mstate == M_IDLE) [*2];
  endproperty

  a_ack_lrb: assert property (p_ack_lrb) else $error("Ack not recorded.");
  a_noack_lrb: assert property (p_noack_lrb) else $error("Last bit lost.");
  a_data_write: assert property (p_data_write) else $error("Write clear failed.");
  a_gcall_clear: assert property (p_gcall_clear) else $error("Call flag kept.");
  a_irq: assert property (p_irq) else $error("Missing interrupt pulse.");
  a_hold_scl: assert property (p_hold_scl) else $error("Clock not held.");
  a_disabled: assert property (p_disabled) else $error("Disabled state wrong.");
  a_stop: assert property (p_stop) else $error("Stop left mode set.");
  a_arb: assert property (p_arb) else $error("Arbitration loss missed.");
  a_blocked: assert property (p_blocked) else $error("Start not blocked.");
endmodule
`default_nettype wire

// File: i2c_bus_peer.sv
// Behavioural model of another master on the shared two-wire bus.
`default_nettype none
module i2c_bus_peer (
  input wire logic CLK,
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_oe_n,
  output logic sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both lines start released; the pull-ups hold them high.
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  // Half of the 160 ns link period at the 10 ns system clock.
  task automatic half();
    repeat (8) @(posedge CLK);
  endtask
  // Releasing the clock waits on the line, so a stretching device holds us back.
  task automatic scl_up();
    scl_oe_n <= 1'b1;
    @(posedge CLK);
    while (!scl_line) @(posedge CLK);
    half();
  endtask
  task automatic grab();
    scl_oe_n <= 1'b0;
    half();
  endtask
  task automatic start_cond();
    half();
    sda_oe_n <= 1'b0;
    half();
    scl_oe_n <= 1'b0;
  endtask
  // Data changes only in mid low phase, so no bit is mistaken for START or STOP.
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      half();
      sda_oe_n <= b[i];
      half();
      scl_up();
      scl_oe_n <= 1'b0;
    end
    half();
    sda_oe_n <= 1'b1;
  endtask
  task automatic stop_cond();
    grab();
    sda_oe_n <= 1'b0;
    half();
    scl_up();
    sda_oe_n <= 1'b1;
    half();
  endtask
  task automatic drive_sda(input logic low);
    sda_oe_n <= ~low;
  endtask
endmodule
`default_nettype wire

// File: i2c_status_mode_control_bench.sv
// Self-checking bench of the two-wire status and mode block.
`default_nettype none
module i2c_status_mode_control_bench
  import i2c_status_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] addr;
    logic [7:0] stat;
  } row_t;
  // Control value, address byte sent by the peer, status expected after it.
  localparam row_t ROWS [0:5] = '{'{8'h01, 8'h00, 8'h26}, '{8'h01, 8'ha5, 8'h65},
    '{8'h01, 8'h37, 8'h31}, '{8'h05, 8'ha5, 8'h31}, '{8'h05, 8'ha4, 8'h24},
    '{8'h03, 8'h36, 8'h20}};
  logic CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic [3:0] AWADDR, ARADDR, WSTRB;
  logic [31:0] WDATA, RDATA, st;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic SCL_OUT, SCL_OE_N, SDA_OUT, SDA_OE_N, IRQ;
  logic [1:0] BRESP, RRESP, rs;
  logic peer_scl, peer_sda, scl_line, sda_line;
  int bad_count, checked, cycles, irqs, i0;
  i2c_status_mode uut (.CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .SCL_IN(scl_line), .SCL_OUT(SCL_OUT), .SCL_OE_N(SCL_OE_N), .SDA_IN(sda_line),
    .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .IRQ(IRQ));
  i2c_bus_peer peer (.CLK(CLK), .scl_line(scl_line), .sda_line(sda_line),
    .scl_oe_n(peer_scl), .sda_oe_n(peer_sda));
  // Open-drain lines with pull-ups: any party driving low wins.
  assign scl_line = (SCL_OE_N | SCL_OUT) & peer_scl;
  assign sda_line = (SDA_OE_N | SDA_OUT) & peer_sda;
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Interrupt pulses are counted, and a hang is cut short well past the expected run.
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (IRQ === 1'b1) irqs <= irqs + 1;
    if (cycles == 60000) begin
      bad_count++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Ready is looked at mid-cycle, so the handshake edge is known before it arrives.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ta, tw, aw, w, b;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    b = 1'b0;
    while (!(aw && w)) begin
      @(negedge CLK);
      ta = AWVALID && AWREADY;
      tw = WVALID && WREADY;
      @(posedge CLK);
      if (ta) begin
        AWVALID <= 1'b0;
        aw = 1'b1;
      end
      if (tw) begin
        WVALID <= 1'b0;
        w = 1'b1;
      end
    end
    while (!b) begin
      @(negedge CLK);
      b = BVALID;
      rs = BRESP;
      @(posedge CLK);
    end
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    logic t, r;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    t = 1'b0;
    r = 1'b0;
    while (!t) begin
      @(negedge CLK);
      t = ARREADY;
      @(posedge CLK);
    end
    ARVALID <= 1'b0;
    while (!r) begin
      @(negedge CLK);
      r = RVALID;
      st = RDATA;
      rs = RRESP;
      @(posedge CLK);
    end
    RREADY <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] mask, input logic [7:0] exp);
    rd(OFF_STATUS);
    check(what, {24'h0, exp}, st & {24'h0, mask});
  endtask
  // Main sequence: reset, register access, slave rows, then the awkward cases.
  initial begin
    RST = 1'b1;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {AWADDR, ARADDR, WDATA} = '0;
    WSTRB = 4'hf;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    rchk("status after reset", 8'hff, 8'h10);
    wr(OFF_STATUS, 8'h0f);
    check("write resp", {30'h0, RESP_OKAY}, {30'h0, rs});
    rchk("status low nibble", 8'hff, 8'h10);
    rd(4'h2);
    check("unaligned resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    wr(OFF_ADDR, 8'ha4);
    wr(OFF_CTRL, 8'h01);
    wr(OFF_STATUS, 8'h30);
    rchk("busy write as slave", 8'hff, 8'h10);
    $display("register test done");
    foreach (ROWS[k]) begin
      wr(OFF_CTRL, ROWS[k].ctrl);
      i0 = irqs;
      peer.start_cond();
      peer.send_byte(ROWS[k].addr);
      repeat (10) @(posedge CLK);
      @(negedge CLK);
      check("irq pulses", {31'h0, ~ROWS[k].stat[4]}, irqs - i0);
      check("clock hold", {31'h0, ROWS[k].stat[4]}, {31'h0, SCL_OE_N});
      rchk("address status", 8'hff, ROWS[k].stat);
      wr(OFF_DATA, 8'hff);
      rchk("after data write", 8'hff, (ROWS[k].stat & 8'hf2) | 8'h10);
      peer.stop_cond();
      repeat (10) @(posedge CLK);
      rchk("after stop", 8'hff, 8'h10);
      $display("slave row %0d done", k);
    end
    // The peer pulls data low while our master sends ones.
    wr(OFF_DATA, 8'hff);
    i0 = irqs;
    wr(OFF_STATUS, 8'hf0);
    while (scl_line) @(posedge CLK);
    peer.drive_sda(1'b1);
    while (irqs == i0) @(posedge CLK);
    repeat (10) @(posedge CLK);
    rchk("lost arbitration", 8'hd8, 8'h08);
    peer.drive_sda(1'b0);
    peer.grab();
    wr(OFF_DATA, 8'hff);
    peer.stop_cond();
    repeat (10) @(posedge CLK);
    rchk("bus after stop", 8'he0, 8'h00);
    $display("arbitration test done");
    // A START request while another master owns the bus must not reach the lines.
    peer.start_cond();
    repeat (10) @(posedge CLK);
    wr(OFF_STATUS, 8'hf0);
    i0 = 0;
    repeat (1100) begin
      @(negedge CLK);
      if (SDA_OE_N !== 1'b1 || SCL_OE_N !== 1'b1) i0++;
    end
    check("lines driven", 32'h0, i0);
    rchk("blocked start", 8'he0, 8'h20);
    wr(OFF_CTRL, 8'h00);
    rchk("disabled", 8'h30, 8'h10);
    wr(OFF_CTRL, 8'h01);
    peer.stop_cond();
    $display("blocked start test done");
    // Our master sends a byte of ones unopposed, must hold the clock, then stops.
    wr(OFF_DATA, 8'hff);
    i0 = irqs;
    wr(OFF_STATUS, 8'hf0);
    while (irqs == i0) @(posedge CLK);
    repeat (600) @(posedge CLK);
    @(negedge CLK);
    check("master clock hold", 32'h0, {31'h0, SCL_OE_N});
    rchk("master byte sent", 8'hff, 8'he1);
    wr(OFF_STATUS, 8'hd0);
    repeat (1100) @(posedge CLK);
    rchk("master stop", 8'hf0, 8'h10);
    $display("master test done");
    // Acknowledge clock mode: our own acknowledge is recorded, then a refused address.
    wr(OFF_CTRL, 8'h09);
    peer.start_cond();
    peer.send_byte(8'ha4);
    @(negedge CLK);
    check("ack driven", 32'h0, {31'h0, SDA_OE_N});
    peer.scl_up();
    peer.grab();
    rchk("ack recorded", 8'hff, 8'h24);
    wr(OFF_DATA, 8'hff);
    peer.stop_cond();
    peer.start_cond();
    peer.send_byte(8'h37);
    peer.scl_up();
    peer.grab();
    rchk("nack recorded", 8'hff, 8'h31);
    peer.stop_cond();
    $display("ack clock test done");
    summarize();
  end
endmodule
`default_nettype wire
